// ==== core/small_wrap_timer.v ====
// Clock selection, prescaler, counter and modulo logic of the small wrap timer
// Function
// - Source select bits 5-4: 00 bus clock, 01 fixed-rate clock
// - Code 10 counts falling pin edges, 11 counts rising pin edges
// - Changing source keeps count; counting continues with new source
// - Reset clears source select to bus clock
// - Prescale codes 0-8 divide by 1,2,4..256 via 8-bit prescaler
// - Prescale codes above 8 divide by 256
// - Changing prescale keeps count; continues at new rate
// - Reset clears prescale select to divide by one
// - Count readable, writes to count register ignored
// - Reset clears count to zero
// - Count reaching wrap limit returns to zero and sets wrap flag
// - Wrap limit zero gives free-running full 8-bit count
// - Any wrap limit write zeroes count and clears wrap flag
// - Reset sets wrap limit to zero
// - Config bits 7-6 read as zero
// - While not halted, count steps once per prescaler output
// - Wrap flag sets on step from limit to zero
// - External input synchronised; source keeps it at most bus/4
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "wrap_timer_regs.vh"

module small_wrap_timer (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Count sources
    input wire fixed_rate_clock,
    input wire external_count_input,
    // Register port
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    // Status
    output reg wrap_flag,
    output reg irq
);

// ----------------------------------------------------------------
// Register state and next values
// ----------------------------------------------------------------
reg [1:0] count_source_select_reg;
reg [1:0] count_source_select_next;
reg [3:0] prescale_select_reg;
reg [3:0] prescale_select_next;
reg [7:0] wrap_limit_value_reg;
reg [7:0] wrap_limit_value_next;
reg count_halt_reg;
reg count_halt_next;
reg irq_mask_reg;
reg irq_mask_next;

// ----------------------------------------------------------------
// Counting state and next values
// ----------------------------------------------------------------
reg [7:0] count_reg;
reg [7:0] count_next;
reg [7:0] prescale_reg;
reg [7:0] prescale_next;
reg wrap_flag_next;
reg irq_status_reg;
reg irq_status_next;
reg irq_next;
reg [7:0] rdata_next;

// ----------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------
wire wr_cfg;
wire wr_limit;
wire wr_ctrl;
wire wr_mask;
wire rd_status;

// The count register has no write decode, so writes to it are lost
assign wr_cfg = wr && (addr == `OFS_CLOCK_CONFIG);
assign wr_limit = wr && (addr == `OFS_WRAP_LIMIT);
assign wr_ctrl = wr && (addr == `OFS_HALT_CTRL);
assign wr_mask = wr && (addr == `OFS_IRQ_MASK);
assign rd_status = rd && (addr == `OFS_IRQ_STATUS);

// ----------------------------------------------------------------
// Source synchronisers and edge enables
// ----------------------------------------------------------------
wire fixed_rise;
wire ext_rise;
wire ext_fall;
reg source_tick;

// Only rising edges of the fixed-rate clock are used
sync_edge_detect #(
    .IDLE_LEVEL(1'b0)
) fixed_sync_u (
    .clock(clock),
    .rst(rst),
    .async_in(fixed_rate_clock),
    .rise(fixed_rise),
    .fall()
);

sync_edge_detect #(
    .IDLE_LEVEL(1'b0)
) ext_sync_u (
    .clock(clock),
    .rst(rst),
    .async_in(external_count_input),
    .rise(ext_rise),
    .fall(ext_fall)
);

// Every source becomes a one-cycle enable on the bus clock
always @* begin
    case (count_source_select_reg)
        `SRC_BUS: begin
            source_tick = 1'b1;
        end
        `SRC_FIXED: begin
            source_tick = fixed_rise;
        end
        `SRC_FALL: begin
            source_tick = ext_fall;
        end
        `SRC_RISE: begin
            source_tick = ext_rise;
        end
        default: begin
            source_tick = 1'b0;
        end
    endcase
end

// ----------------------------------------------------------------
// Prescaler
// ----------------------------------------------------------------
wire [3:0] ps_eff;
wire [8:0] ps_span;
wire [7:0] ps_mask;
wire prescale_tick;

// Codes above the last tap fall back to the divide-by-256 tap
assign ps_eff = (prescale_select_reg > `PS_MAX) ? `PS_MAX : prescale_select_reg;
assign ps_span = 9'h001 << ps_eff;
assign ps_mask = ps_span[7:0] - 8'h01;
// Tick when all prescaler bits below the selected tap are one
assign prescale_tick = source_tick && ((prescale_reg & ps_mask) == ps_mask);

always @* begin
    prescale_next = prescale_reg;
    if (wr_limit) begin
        prescale_next = 8'h00;
    end else if (!count_halt_reg && source_tick) begin
        prescale_next = prescale_reg + 8'h01;
    end
end

// ----------------------------------------------------------------
// Counter and modulo
// ----------------------------------------------------------------
wire step;
wire free_running;
wire at_limit;
wire wrap_event;

assign step = prescale_tick && !count_halt_reg;
assign free_running = (wrap_limit_value_reg == 8'h00);
assign at_limit = free_running ? (count_reg == 8'hFF) : (count_reg == wrap_limit_value_reg);
// A limit write in the same cycle wins, so the wrap is lost with the count
assign wrap_event = step && at_limit && !wr_limit;

always @* begin
    count_next = count_reg;
    if (wr_limit) begin
        count_next = 8'h00;
    end else if (wrap_event) begin
        count_next = 8'h00;
    end else if (step) begin
        count_next = count_reg + 8'h01;
    end
end

always @* begin
    wrap_flag_next = wrap_flag;
    if (wr_limit) begin
        wrap_flag_next = 1'b0;
    end else if (wrap_event) begin
        wrap_flag_next = 1'b1;
    end
end

// ----------------------------------------------------------------
// Software registers
// ----------------------------------------------------------------
// Config write leaves count and prescaler as they are
always @* begin
    count_source_select_next = count_source_select_reg;
    prescale_select_next = prescale_select_reg;
    if (wr_cfg) begin
        count_source_select_next = wdata[`CFG_SRC_HI:`CFG_SRC_LO];
        prescale_select_next = wdata[`CFG_PS_HI:`CFG_PS_LO];
    end
end

always @* begin
    wrap_limit_value_next = wrap_limit_value_reg;
    if (wr_limit) begin
        wrap_limit_value_next = wdata;
    end
end

// Only the halt bit of the control register is writable
always @* begin
    count_halt_next = count_halt_reg;
    if (wr_ctrl) begin
        count_halt_next = wdata[`CTRL_HALT_BIT];
    end
end

// Mask bit 0 gates the level interrupt
always @* begin
    irq_mask_next = irq_mask_reg;
    if (wr_mask) begin
        irq_mask_next = wdata[0];
    end
end

// ----------------------------------------------------------------
// Interrupt
// ----------------------------------------------------------------
// Sticky event bit; a wrap in the clearing read cycle stays set
always @* begin
    irq_status_next = irq_status_reg;
    if (wrap_event) begin
        irq_status_next = 1'b1;
    end else if (rd_status) begin
        irq_status_next = 1'b0;
    end
end

// Level output follows the unmasked sticky bit
always @* begin
    irq_next = irq_status_next && irq_mask_next;
end

// ----------------------------------------------------------------
// Read port
// ----------------------------------------------------------------
always @* begin
    rdata_next = 8'h00;
    if (rd) begin
        case (addr)
            `OFS_HALT_CTRL: begin
                rdata_next = {wrap_flag, 2'h0, count_halt_reg, 4'h0};
            end
            `OFS_CLOCK_CONFIG: begin
                rdata_next = {2'h0, count_source_select_reg, prescale_select_reg};
            end
            `OFS_CURRENT_COUNT: begin
                rdata_next = count_reg;
            end
            `OFS_WRAP_LIMIT: begin
                rdata_next = wrap_limit_value_reg;
            end
            `OFS_IRQ_STATUS: begin
                rdata_next = {7'h00, irq_status_reg};
            end
            `OFS_IRQ_MASK: begin
                rdata_next = {7'h00, irq_mask_reg};
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end
end

always @(posedge clock or posedge rst) begin
    if (rst) begin
        rdata <= 8'h00;
    end else begin
        rdata <= rdata_next;
    end
end

// ----------------------------------------------------------------
// Configuration flip-flops
// ----------------------------------------------------------------
always @(posedge clock or posedge rst) begin
    if (rst) begin
        count_source_select_reg <= `RST_SRC;
        prescale_select_reg <= `RST_PS;
    end else begin
        count_source_select_reg <= count_source_select_next;
        prescale_select_reg <= prescale_select_next;
    end
end

always @(posedge clock or posedge rst) begin
    if (rst) begin
        wrap_limit_value_reg <= `RST_LIMIT;
        count_halt_reg <= `RST_HALT;
        irq_mask_reg <= 1'b0;
    end else begin
        wrap_limit_value_reg <= wrap_limit_value_next;
        count_halt_reg <= count_halt_next;
        irq_mask_reg <= irq_mask_next;
    end
end

// ----------------------------------------------------------------
// Counting flip-flops
// ----------------------------------------------------------------
always @(posedge clock or posedge rst) begin
    if (rst) begin
        count_reg <= `RST_COUNT;
        prescale_reg <= 8'h00;
    end else begin
        count_reg <= count_next;
        prescale_reg <= prescale_next;
    end
end

always @(posedge clock or posedge rst) begin
    if (rst) begin
        wrap_flag <= 1'b0;
        irq_status_reg <= 1'b0;
        irq <= 1'b0;
    end else begin
        wrap_flag <= wrap_flag_next;
        irq_status_reg <= irq_status_next;
        irq <= irq_next;
    end
end

endmodule // small_wrap_timer

// ----------------------------------------------------------------
// Two-stage synchroniser with edge enables
// ----------------------------------------------------------------
module sync_edge_detect #(
    parameter IDLE_LEVEL = 1'b0
) (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Asynchronous level
    input wire async_in,
    // One-cycle edge enables
    output wire rise,
    output wire fall
);

reg meta_reg;
reg stable_reg;
reg last_reg;

// Only stable_reg reads meta_reg; edges are seen one stage later
always @(posedge clock or posedge rst) begin
    if (rst) begin
        meta_reg <= IDLE_LEVEL;
        stable_reg <= IDLE_LEVEL;
        last_reg <= IDLE_LEVEL;
    end else begin
        meta_reg <= async_in;
        stable_reg <= meta_reg;
        last_reg <= stable_reg;
    end
end

assign rise = stable_reg && !last_reg;
assign fall = !stable_reg && last_reg;

endmodule // sync_edge_detect

// ==== core/wrap_timer_regs.vh ====
// Register offsets, field positions and reset values of the small wrap timer
`ifndef WRAP_TIMER_REGS_VH
`define WRAP_TIMER_REGS_VH

`define OFS_HALT_CTRL 8'h18
`define OFS_CLOCK_CONFIG 8'h19
`define OFS_CURRENT_COUNT 8'h1A
`define OFS_WRAP_LIMIT 8'h1B
`define OFS_IRQ_STATUS 8'h1C
`define OFS_IRQ_MASK 8'h1D

`define CFG_SRC_HI 5
`define CFG_SRC_LO 4
`define CFG_PS_HI 3
`define CFG_PS_LO 0
`define CTRL_HALT_BIT 4
`define CTRL_FLAG_BIT 7

`define SRC_BUS 2'h0
`define SRC_FIXED 2'h1
`define SRC_FALL 2'h2
`define SRC_RISE 2'h3

`define RST_SRC 2'h0
`define RST_PS 4'h0
`define RST_COUNT 8'h00
`define RST_LIMIT 8'h00
`define RST_HALT 1'h1
`define PS_MAX 4'h8

`endif

// ==== tb/testbench.sv ====
// Self-checking testbench of the small wrap timer
`timescale 1ns/1ps
module testbench;
reg clock = 0, rst = 1, wr = 0, rd = 0, fixed_rate_clock = 0, external_count_input = 0;
reg [7:0] addr = 8'h00, wdata = 8'h00, tick = 8'h00, v;
wire [7:0] rdata;
wire wrap_flag, irq;
integer n_mismatch = 0, checks_done = 0, cyc = 0, i;
small_wrap_timer dut_u (.clock(clock), .rst(rst), .fixed_rate_clock(fixed_rate_clock),
    .external_count_input(external_count_input), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .wrap_flag(wrap_flag), .irq(irq));
always #2.5 clock = ~clock;
// Slow sources: fixed clock period 8, pin period 16; also the hang limit
always @(posedge clock) begin
    tick <= tick + 8'h01;
    fixed_rate_clock <= tick[2];
    external_count_input <= tick[3];
    cyc = cyc + 1;
    if (cyc == 60000) begin
        n_mismatch = n_mismatch + 1;
        end_of_test;
    end
end
task wreg(input [7:0] a, input [7:0] d);
begin
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
end
endtask
task rreg(input [7:0] a);
begin
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 v = rdata;
end
endtask
task chk(input [7:0] lo, input [7:0] hi);
begin
    checks_done = checks_done + 1;
    if ((v >= lo && v <= hi) !== 1'b1) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0t: got %h, want %h..%h", $time, v, lo, hi);
    end
end
endtask
// Clear, run n cycles, switch config, run m more, halt and read count
task run(input [7:0] c, input integer n, input [7:0] c2, input integer m, input [7:0] lo, input [7:0] hi);
begin
    wreg(8'h19, c);
    wreg(8'h1B, 8'h00);
    wreg(8'h18, 8'h00);
    repeat (n) @(posedge clock);
    wreg(8'h19, c2);
    repeat (m) @(posedge clock);
    wreg(8'h18, 8'h10);
    rreg(8'h1A);
    chk(lo, hi);
end
endtask
task end_of_test;
begin
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
end
endtask
initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rreg(8'h19);
    chk(8'h00, 8'h00);
    rreg(8'h1B);
    chk(8'h00, 8'h00);
    wreg(8'h1A, 8'h55);
    rreg(8'h1A);
    chk(8'h00, 8'h00);
    wreg(8'h19, 8'hFF);
    rreg(8'h19);
    chk(8'h3F, 8'h3F);
    for (i = 0; i < 10; i = i + 1)
        run(i, 32 << (i > 8 ? 8 : i), i, 0, 32 + (4 >> i), 32 + (4 >> i));
    run(8'h10, 256, 8'h10, 0, 8'd29, 8'd35);
    run(8'h20, 256, 8'h30, 256, 8'd29, 8'd35);
    run(8'h00, 16, 8'h01, 32, 8'd35, 8'd35);
    wreg(8'h1D, 8'h01);
    wreg(8'h19, 8'h00);
    wreg(8'h1B, 8'h03);
    wreg(8'h18, 8'h00);
    repeat (21) @(posedge clock);
    wreg(8'h18, 8'h10);
    rreg(8'h1A);
    chk(8'h03, 8'h03);
    rreg(8'h18);
    chk(8'h90, 8'h90);
    v = {7'h00, irq};
    chk(8'h01, 8'h01);
    rreg(8'h1C);
    chk(8'h01, 8'h01);
    wreg(8'h1B, 8'h00);
    v = {7'h00, wrap_flag | irq};
    chk(8'h00, 8'h00);
    wreg(8'h18, 8'h00);
    repeat (270) @(posedge clock);
    v = {7'h00, wrap_flag};
    chk(8'h01, 8'h01);
    wreg(8'h18, 8'h10);
    rreg(8'h1A);
    chk(8'h10, 8'h10);
    end_of_test;
end
endmodule // testbench

// ==== tb/wrap_timer_monitor.sv ====
// Port checker of the small wrap timer
`timescale 1ns/1ps
module wrap_timer_monitor (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Count sources
    input wire fixed_rate_clock,
    input wire external_count_input,
    // Register port
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    // Status
    input wire wrap_flag,
    input wire irq
);
default clocking cb @(posedge clock); endclocking
default disable iff (rst);
property p_rd_idle; !$past(rd) |-> rdata == 8'h00; endproperty
a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
property p_cfg_top; $past(rd) && $past(addr) == 8'h19 |-> rdata[7:6] == 2'b00; endproperty
a_cfg_top: assert property (p_cfg_top) else $error("config top bits set");
property p_ctrl_flag; $past(rd) && $past(addr) == 8'h18 |-> rdata[7] == $past(wrap_flag); endproperty
a_ctrl_flag: assert property (p_ctrl_flag) else $error("flag readback wrong");
property p_stat_bits; $past(rd) && $past(addr) == 8'h1C |-> rdata[7:1] == 7'h00; endproperty
a_stat_bits: assert property (p_stat_bits) else $error("status spare bits set");
property p_lim_flag; $past(wr) && $past(addr) == 8'h1B |-> !wrap_flag; endproperty
a_lim_flag: assert property (p_lim_flag) else $error("flag kept after limit write");
property p_flag_stay; wrap_flag && !(wr && addr == 8'h1B) |=> wrap_flag; endproperty
a_flag_stay: assert property (p_flag_stay) else $error("flag lost");
property p_irq_cause; $rose(irq) |-> wrap_flag || $past(wr); endproperty
a_irq_cause: assert property (p_irq_cause) else $error("irq without wrap");
property p_rst_out; $fell(rst) |-> !wrap_flag && !irq && rdata == 8'h00; endproperty
a_rst_out: assert property (p_rst_out) else $error("outputs not clear after reset");
c_wrap: cover property ($rose(wrap_flag));
c_irq: cover property ($rose(irq));
c_lim: cover property (wr && addr == 8'h1B);
endmodule // wrap_timer_monitor
bind small_wrap_timer wrap_timer_monitor mon_u (.clock(clock), .rst(rst), .fixed_rate_clock(fixed_rate_clock),
    .external_count_input(external_count_input), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .wrap_flag(wrap_flag), .irq(irq));
